/* File: rtl/wl_pkg.sv */
// constants shared by both ends of the write leveling link
// assumes a single 10 MHz system clock on both ends
package wl_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MODE_SET_DELAY_NS = 2400;
  localparam int MODE_CMD_CYCLE_NS = 800;
  localparam int LEVEL_STROBE_EN_NS = 2500;
  localparam int LEVEL_FIRST_EDGE_NS = 4000;
  localparam int STROBE_LOW_NS = 900;
  localparam int LEVEL_FB_DELAY_NS = 900;
  // least times round up
  localparam int MODE_SET_CYC = (MODE_SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_CMD_CYC = (MODE_CMD_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_EN_CYC = (LEVEL_STROBE_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIRST_EDGE_CYC = (LEVEL_FIRST_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest time rounds down, never below one cycle
  localparam int FB_CYC_RAW = LEVEL_FB_DELAY_NS / CLK_PERIOD_NS;
  localparam int FB_CYC = (FB_CYC_RAW < 1) ? 1 : FB_CYC_RAW;

  // ==========================================================
  // link shape
  localparam int NUM_LANES = 2;
  localparam int LANE_BITS = 8;
  localparam int MR_W = 13;

  // ==========================================================
  // mode register select codes and fields
  localparam logic [2:0] SEL_MODE_1 = 3'h1;
  localparam logic [2:0] SEL_MODE_2 = 3'h2;
  localparam logic [2:0] SEL_MODE_5 = 3'h5;
  localparam int LVL_EN_BIT = 7;
  localparam int QOFF_BIT = 12;
  localparam int DYN_TERM_LSB = 9;
  localparam int NOM_LSB = 8;
  localparam int PARK_LSB = 6;
  localparam logic [MR_W-1:0] MR_RESET = 13'h0000;

  // ==========================================================
  // controller register map (apb, byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_DELAY = 12'h008;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_QOFF_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_LOCK_LSB = 2;
  localparam int CK_HALF_DEF = 4;

endpackage

/* File: rtl/wl_if.sv */
// pins between the memory controller and the dram leveling logic
// assumes both ends share one clock; this file resolves shared wires
interface wl_if;
  import wl_pkg::*;
  logic mrs_valid;
  logic [2:0] mrs_sel;
  logic [MR_W-1:0] mrs_data;
  logic term_ctl;
  logic mem_clk;
  logic [NUM_LANES-1:0] strobe;
  logic [NUM_LANES-1:0] strobe_n;
  logic [NUM_LANES-1:0] strobe_oe;
  logic [NUM_LANES-1:0] strobe_lvl;
  logic [NUM_LANES*LANE_BITS-1:0] dq_o;
  logic [NUM_LANES*LANE_BITS-1:0] dq_oe;
  logic [NUM_LANES*LANE_BITS-1:0] dq;

  // ==========================================================
  // wire resolution: undriven lines sit at the terminated low level
  assign strobe_lvl = strobe & strobe_oe;
  assign dq = dq_o & dq_oe;

  modport ctl(output mrs_valid, mrs_sel, mrs_data, term_ctl, mem_clk, strobe, strobe_n, strobe_oe,
              input dq);
  modport dev(input mrs_valid, mrs_sel, mrs_data, term_ctl, mem_clk, strobe_lvl,
              output dq_o, dq_oe);
endinterface

/* File: rtl/wl_lane_sampler.sv */
// one byte lane: samples the memory clock on a strobe rise
// assumes strobe and clock are synchronous to clk_i
module wl_lane_sampler
  import wl_pkg::*;
#(
  parameter int FB_DELAY = FB_CYC
) (
  input logic clk_i,      // system clock
  input logic arst_n_i,   // async reset, low
  input logic ce_i,       // clock enable
  input logic en_i,       // leveling active
  input logic strobe_i,   // lane strobe level
  input logic mem_clk_i,  // memory clock level
  output logic fb_o,      // feedback level
  output logic started_o  // first feedback given
);
  logic strobe_q;
  logic cap;
  logic [7:0] cnt;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strobe_q <= 1'b0;
      cap <= 1'b0;
      cnt <= 8'h00;
      fb_o <= 1'b0;
      started_o <= 1'b0;
    end else if (ce_i) begin
      strobe_q <= strobe_i;
      if (!en_i) begin
        cnt <= 8'h00;
        started_o <= 1'b0;
      end else if (strobe_i && !strobe_q) begin
        cap <= mem_clk_i;
        cnt <= 8'(FB_DELAY);
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          fb_o <= cap;
          started_o <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: rtl/wl_device.sv */
// dram side write leveling: mode register decode, lane feedback, termination
// assumes the controller keeps the command and timing rules of the procedure
//
// Notes on behaviour
// - bit 7 of register one enters/leaves leveling
// - bit 12 set turns data outputs off
// - leveling: strobe termination only, nominal or park
// - any termination setting accepted while leveling
// - controller clears dynamic termination before entry
// - only deselect or register-one commands while leveling
// - exit command also applies other register bits
// - data lines undefined from entry until feedback
// - controller waits mode_set_delay before termination control
// - strobe termination ready before strobe driven
// - one strobe rise per trial after setup
// - sample clock on rise, feed back later
// - no read strobes while giving feedback
// - controller steps delay, locks on 0-to-1
// - each byte lane leveled on its own
// - other ranks keep output buffer off
// - exit: stop strobes, termination low, then command
// - lines undefined mode_set_delay after exit command
module wl_device
  import wl_pkg::*;
#(
  parameter int EXIT_CYC = MODE_SET_CYC
) (
  input logic clk_i,                // system clock
  input logic arst_n_i,             // async reset, low
  input logic ce_i,                 // clock enable
  wl_if.dev link,                   // pins to controller
  output logic lvl_mode_o,          // leveling mode active
  output logic out_buf_off_o,       // output buffer off
  output logic strobe_term_on_o,    // strobe termination on
  output logic strobe_term_nom_o,   // 1 nominal, 0 park
  output logic dq_term_on_o,        // data termination on
  output logic [2:0] nom_setting_o, // nominal strength
  output logic [2:0] park_setting_o,// park strength
  output logic [2:0] dyn_setting_o, // dynamic term field
  output logic [NUM_LANES-1:0] fb_o // lane feedback seen
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    DS_NORMAL = 2'b00,
    DS_UNDEF = 2'b01,
    DS_FEEDBACK = 2'b10,
    DS_EXIT = 2'b11
  } dev_state_t;

  dev_state_t state;
  dev_state_t next_state;
  logic [MR_W-1:0] mode_register_1;
  logic [MR_W-1:0] mode_register_2;
  logic [MR_W-1:0] mode_register_5;
  logic [7:0] exit_cnt;
  logic lvl;
  logic qoff;
  logic [NUM_LANES-1:0] lane_fb;
  logic [NUM_LANES-1:0] lane_started;

  assign lvl = mode_register_1[LVL_EN_BIT];
  assign qoff = mode_register_1[QOFF_BIT];

  // ==========================================================
  // mode registers
  // the whole word is taken on each write, so an exit command
  // carries its other bit changes along with it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_register_1 <= MR_RESET;
      mode_register_2 <= MR_RESET;
      mode_register_5 <= MR_RESET;
    end else if (ce_i && link.mrs_valid) begin
      case (link.mrs_sel)
        SEL_MODE_1: begin
          mode_register_1 <= link.mrs_data;
        end
        SEL_MODE_2: begin
          mode_register_2 <= link.mrs_data;
        end
        SEL_MODE_5: begin
          mode_register_5 <= link.mrs_data;
        end
        default: begin
          mode_register_1 <= mode_register_1;
        end
      endcase
    end
  end

  // ==========================================================
  // leveling sequence
  always_comb begin
    next_state = state;
    case (state)
      DS_NORMAL: begin
        if (lvl) begin
          next_state = DS_UNDEF;
        end
      end
      DS_UNDEF: begin
        if (!lvl) begin
          next_state = DS_EXIT;
        end else if (|lane_started) begin
          next_state = DS_FEEDBACK;
        end
      end
      DS_FEEDBACK: begin
        if (!lvl) begin
          next_state = DS_EXIT;
        end
      end
      DS_EXIT: begin
        if (lvl) begin
          next_state = DS_UNDEF;
        end else if (exit_cnt == 8'h01) begin
          next_state = DS_NORMAL;
        end
      end
      default: begin
        next_state = DS_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= DS_NORMAL;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // lines stay undefined for the whole mode_set_delay after exit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      exit_cnt <= 8'h00;
    end else if (ce_i) begin
      if (state != DS_EXIT && next_state == DS_EXIT) begin
        exit_cnt <= 8'(EXIT_CYC);
      end else if (exit_cnt != 8'h00) begin
        exit_cnt <= exit_cnt - 8'h01;
      end
    end
  end

  // ==========================================================
  // per lane sampling and feedback drive
  // lanes run apart so each byte reports its own strobe
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++) begin : g_lane
      wl_lane_sampler #(
        .FB_DELAY(FB_CYC)
      ) u_lane (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .en_i(lvl),
        .strobe_i(link.strobe_lvl[g]),
        .mem_clk_i(link.mem_clk),
        .fb_o(lane_fb[g]),
        .started_o(lane_started[g])
      );

      // feedback rides the data lines alone; no read strobe is
      // driven, so the controller samples the lines directly
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          link.dq_o[g*LANE_BITS +: LANE_BITS] <= '0;
          link.dq_oe[g*LANE_BITS +: LANE_BITS] <= '0;
        end else if (ce_i) begin
          if (next_state == DS_FEEDBACK && lane_started[g]) begin
            link.dq_o[g*LANE_BITS +: LANE_BITS] <= {LANE_BITS{lane_fb[g]}};
          end else begin
            link.dq_o[g*LANE_BITS +: LANE_BITS] <= '0;
          end
          // all bits switch on one edge, well inside level_feedback_skew
          link.dq_oe[g*LANE_BITS +: LANE_BITS] <=
            {LANE_BITS{(next_state != DS_NORMAL) && !qoff}};
        end
      end
    end
  endgenerate

  // ==========================================================
  // termination
  // in leveling the pin only picks nominal against park for the
  // strobes; the data lines are left open so the controller end
  // terminates the feedback
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strobe_term_on_o <= 1'b0;
      strobe_term_nom_o <= 1'b0;
      dq_term_on_o <= 1'b0;
    end else if (ce_i) begin
      strobe_term_nom_o <= link.term_ctl;
      if (lvl) begin
        strobe_term_on_o <= 1'b1;
        dq_term_on_o <= 1'b0;
      end else begin
        strobe_term_on_o <= link.term_ctl;
        dq_term_on_o <= link.term_ctl;
      end
    end
  end

  // ==========================================================
  // status outputs
  // settings pass through untouched whatever the buffer mode
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lvl_mode_o <= 1'b0;
      out_buf_off_o <= 1'b0;
      nom_setting_o <= 3'h0;
      park_setting_o <= 3'h0;
      dyn_setting_o <= 3'h0;
      fb_o <= '0;
    end else if (ce_i) begin
      lvl_mode_o <= lvl;
      out_buf_off_o <= qoff;
      nom_setting_o <= mode_register_1[NOM_LSB +: 3];
      park_setting_o <= mode_register_5[PARK_LSB +: 3];
      dyn_setting_o <= mode_register_2[DYN_TERM_LSB +: 3];
      fb_o <= lane_fb & lane_started;
    end
  end

endmodule

/* File: rtl/wl_controller.sv */
// controller side of write leveling, driven by software over apb
// assumes the dram end answers as the leveling procedure describes
//
// Our own choices: the register offsets and the APB slave port.
module wl_controller
  import wl_pkg::*;
#(
  parameter int CK_HALF = CK_HALF_DEF
) (
  input logic clk_i,            // system clock, also pclk
  input logic arst_n_i,         // async reset, low
  input logic ce_i,             // clock enable
  input logic psel_i,           // apb select
  input logic penable_i,        // apb enable
  input logic pwrite_i,         // apb write
  input logic [11:0] paddr_i,   // apb byte address
  input logic [31:0] pwdata_i,  // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o,        // apb ready
  output logic pslverr_o,       // apb error
  wl_if.ctl link                // pins to dram
);
  localparam int DW = $clog2(2 * CK_HALF);
  localparam logic [DW-1:0] LAST_PH = DW'(2 * CK_HALF - 1);
  localparam int SETUP_CYC = (STROBE_LOW_CYC > FIRST_EDGE_CYC) ? STROBE_LOW_CYC : FIRST_EDGE_CYC;

  typedef enum logic [3:0] {
    C_IDLE = 4'b0000, C_DYN = 4'b0001, C_ENTER = 4'b0010, C_WAIT_MOD = 4'b0011,
    C_TERM = 4'b0100, C_LOW = 4'b0101, C_ARM = 4'b0110, C_TRIAL = 4'b0111,
    C_SAMPLE = 4'b1000, C_STOP = 4'b1001, C_EXIT = 4'b1010, C_WAIT_EXIT = 4'b1011
  } ctl_state_t;

  ctl_state_t state;
  logic [7:0] cnt;
  logic [DW-1:0] phase;
  logic [DW-1:0] delay [NUM_LANES];
  logic [NUM_LANES-1:0] locked;
  logic [NUM_LANES-1:0] prev_fb;
  logic start;
  logic qoff;
  logic done;
  logic acc;

  // ==========================================================
  // apb slave: zero wait, ready in the first access cycle
  assign acc = psel_i && penable_i && pready_o;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      start <= 1'b0;
      qoff <= 1'b0;
      done <= 1'b0;
    end else if (ce_i) begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      start <= 1'b0;
      if (psel_i && !penable_i) begin
        prdata_o <= 32'h0000_0000;
        case (paddr_i)
          OFS_CTRL: prdata_o[CTRL_QOFF_BIT] <= qoff;
          OFS_STATUS: prdata_o[STAT_LOCK_LSB+1:0] <= {locked, done, state != C_IDLE};
          OFS_DELAY: prdata_o[15:0] <= {8'(delay[1]), 8'(delay[0])};
          default: pslverr_o <= 1'b1;
        endcase
      end
      if (acc && pwrite_i && paddr_i == OFS_CTRL) begin
        start <= pwdata_i[CTRL_START_BIT];
        qoff <= pwdata_i[CTRL_QOFF_BIT];
      end
      // completion wins over a clear in the same cycle
      if (state == C_WAIT_EXIT && cnt == 8'h01) begin
        done <= 1'b1;
      end else if (acc && pwrite_i && paddr_i == OFS_STATUS && pwdata_i[STAT_DONE_BIT]) begin
        done <= 1'b0;
      end else if (start) begin
        done <= 1'b0;
      end
    end
  end

  // ==========================================================
  // memory clock: free running divider, phase is the delay reference
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase <= '0;
      link.mem_clk <= 1'b0;
    end else if (ce_i) begin
      phase <= (phase == LAST_PH) ? '0 : phase + DW'(1);
      link.mem_clk <= phase >= DW'(CK_HALF);
    end
  end

  // ==========================================================
  // sequence
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= C_IDLE;
      cnt <= 8'h00;
      link.mrs_valid <= 1'b0;
      link.mrs_sel <= 3'h0;
      link.mrs_data <= MR_RESET;
      link.term_ctl <= 1'b0;
      link.strobe_oe <= '0;
    end else if (ce_i) begin
      link.mrs_valid <= 1'b0;
      if (cnt != 8'h00) cnt <= cnt - 8'h01;
      case (state)
        C_IDLE: if (start) state <= C_DYN;
        C_DYN: begin
          link.mrs_valid <= 1'b1;
          link.mrs_sel <= SEL_MODE_2;
          link.mrs_data <= MR_RESET;
          cnt <= 8'(MODE_CMD_CYC);
          state <= C_ENTER;
        end
        C_ENTER: if (cnt == 8'h00) begin
          link.mrs_valid <= 1'b1;
          link.mrs_sel <= SEL_MODE_1;
          link.mrs_data <= MR_RESET | (13'h0001 << LVL_EN_BIT) | (MR_W'(qoff) << QOFF_BIT);
          cnt <= 8'(MODE_SET_CYC);
          state <= C_WAIT_MOD;
        end
        C_WAIT_MOD: if (cnt == 8'h00) begin
          link.term_ctl <= 1'b1;
          cnt <= 8'(STROBE_EN_CYC);
          state <= C_TERM;
        end
        C_TERM: if (cnt == 8'h00) begin
          link.strobe_oe <= '1;
          cnt <= 8'(SETUP_CYC);
          state <= C_LOW;
        end
        C_LOW: if (cnt == 8'h00) state <= C_ARM;
        C_ARM: if (phase == LAST_PH) state <= C_TRIAL;
        C_TRIAL: if (phase == LAST_PH) begin
          cnt <= 8'(FB_CYC + 3);
          state <= C_SAMPLE;
        end
        C_SAMPLE: if (cnt == 8'h01) state <= (&next_lock()) ? C_STOP : C_ARM;
        C_STOP: begin
          link.strobe_oe <= '0;
          link.term_ctl <= 1'b0;
          cnt <= 8'(MODE_CMD_CYC);
          state <= C_EXIT;
        end
        C_EXIT: if (cnt == 8'h00) begin
          link.mrs_valid <= 1'b1;
          link.mrs_sel <= SEL_MODE_1;
          link.mrs_data <= MR_RESET | (MR_W'(qoff) << QOFF_BIT);
          cnt <= 8'(MODE_SET_CYC);
          state <= C_WAIT_EXIT;
        end
        C_WAIT_EXIT: if (cnt == 8'h01) state <= C_IDLE;
        default: state <= C_IDLE;
      endcase
    end
  end

  function automatic logic [NUM_LANES-1:0] next_lock();
    logic [NUM_LANES-1:0] r;
    r = locked;
    for (int i = 0; i < NUM_LANES; i++) begin
      if (!prev_fb[i] && link.dq[i*LANE_BITS]) r[i] = 1'b1;
    end
    return r;
  endfunction

  // ==========================================================
  // per lane strobe and delay sweep
  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++) begin : g_lane
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          delay[g] <= '0;
          locked[g] <= 1'b0;
          prev_fb[g] <= 1'b1;
          link.strobe[g] <= 1'b0;
          link.strobe_n[g] <= 1'b1;
        end else if (ce_i) begin
          // a single rise per trial at this lane's delay
          link.strobe[g] <= (state == C_TRIAL) && (phase >= delay[g]);
          link.strobe_n[g] <= !((state == C_TRIAL) && (phase >= delay[g]));
          if (state == C_IDLE && start) begin
            delay[g] <= '0;
            locked[g] <= 1'b0;
            prev_fb[g] <= 1'b1;  // the first sample alone never locks
          end else if (state == C_SAMPLE && cnt == 8'h01 && !locked[g]) begin
            prev_fb[g] <= link.dq[g*LANE_BITS];
            if (!prev_fb[g] && link.dq[g*LANE_BITS]) begin
              locked[g] <= 1'b1;
            end else begin
              delay[g] <= delay[g] + DW'(1);
            end
          end
        end
      end
    end
  endgenerate

endmodule

/* File: verif/wl_link_props.sv */
// checker: timing and level relations on the leveling link pins
// assumes one clock domain and the resolved wires of wl_if
module wl_link_props
  import wl_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // reset, low
  input wire logic mrs_valid, // mode write
  input wire logic [2:0] mrs_sel, // register select
  input wire logic [MR_W-1:0] mrs_data, // register word
  input wire logic term_ctl, // termination control
  input wire logic mem_clk, // memory clock
  input wire logic [NUM_LANES-1:0] strobe_oe, // strobe drive
  input wire logic [NUM_LANES-1:0] strobe_lvl, // resolved strobe
  input wire logic [NUM_LANES*LANE_BITS-1:0] dq_oe, // data drive
  input wire logic [NUM_LANES*LANE_BITS-1:0] dq // resolved data
);
  // strobe rise to feedback seen on the pins: sampler count, its output flop, the data flop
  localparam int FBD = FB_CYC + 2;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ==========================================================
  // helper state seen from the pins
  logic lvl;
  logic dyn0;
  logic [11:0] gap;
  wire logic wr1 = mrs_valid && mrs_sel == SEL_MODE_1;
  wire logic entry = wr1 && mrs_data[LVL_EN_BIT];
  wire logic leave = wr1 && !mrs_data[LVL_EN_BIT] && lvl;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lvl <= 1'b0;
      dyn0 <= 1'b1;
      gap <= 12'h000;
    end else begin
      if (wr1) lvl <= mrs_data[LVL_EN_BIT];
      if (mrs_valid && mrs_sel == SEL_MODE_2) dyn0 <= mrs_data[DYN_TERM_LSB+:3] == 3'h0;
      // saturates so long idle stretches never wrap
      gap <= mrs_valid ? 12'h001 : gap + 12'(!(&gap));
    end
  end
  // ==========================================================
  // assertions
  a_entry_dyn_clear: assert property (entry |-> dyn0)
    else $error("leveling entered with dynamic termination set");
  a_cmd_while_lvl: assert property (mrs_valid && lvl |-> mrs_sel == SEL_MODE_1)
    else $error("foreign register write while leveling");
  a_term_wait: assert property ($rose(term_ctl) |-> gap >= MODE_SET_CYC - 1)
    else $error("termination control raised too early");
  a_strobe_term: assert property (strobe_oe != '0 |-> term_ctl)
    else $error("strobe driven without termination control");
  a_exit_order: assert property (leave |-> strobe_oe == '0 && !term_ctl && !$past(term_ctl, 8))
    else $error("exit write before strobes and termination released");
  a_exit_hold: assert property (leave |=> dq_oe[0] [*8] ##[16:18] dq_oe == '0)
    else $error("data lines released at the wrong time after exit");
  a_entry_undef: assert property (entry && !mrs_data[QOFF_BIT] |-> ##2 dq_oe[0] && dq == '0)
    else $error("data lines not parked low after entry");
  a_qoff_quiet: assert property (entry && mrs_data[QOFF_BIT] |-> ##2 dq_oe == '0)
    else $error("data lines driven with output buffer off");
  a_fb_lower: assert property ($rose(strobe_lvl[0]) && dq_oe[0] |-> ##FBD dq[0] == $past(mem_clk, FBD))
    else $error("lower lane feedback wrong");
  a_fb_upper: assert property ($rose(strobe_lvl[1]) && dq_oe[8] |-> ##FBD dq[8] == $past(mem_clk, FBD))
    else $error("upper lane feedback wrong");
  a_lane_equal: assert property (dq[7:0] inside {8'h00, 8'hFF} && dq[15:8] inside {8'h00, 8'hFF})
    else $error("bits of one lane disagree");
  c_entry: cover property (entry);
  c_fb_high: cover property (dq[0] && dq[8]);
  c_leave: cover property (leave);
endmodule

/* File: verif/write_leveling_mode_tb.sv */
// bench: controller and dram ends joined by wl_if, software over apb
// assumes the default memory clock half period of the controller
module write_leveling_mode_tb
  import wl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000, a;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, seed = 32'h0000_0050;
  logic pready_o, pslverr_o, lvl_mode_o, out_buf_off_o, strobe_term_on_o, strobe_term_nom_o, dq_term_on_o;
  logic [2:0] dyn_setting_o, nom_setting_o, park_setting_o;
  logic [1:0] fb_o;
  logic [32:0] expq[$], e;
  int bad_count = 0, checked = 0;
  wl_if link();
  wl_controller i_wl_controller(.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .link(link.ctl));
  wl_device i_wl_device(.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .link(link.dev),
    .lvl_mode_o(lvl_mode_o), .out_buf_off_o(out_buf_off_o), .strobe_term_on_o(strobe_term_on_o),
    .strobe_term_nom_o(strobe_term_nom_o), .dq_term_on_o(dq_term_on_o), .nom_setting_o(nom_setting_o),
    .park_setting_o(park_setting_o), .dyn_setting_o(dyn_setting_o), .fb_o(fb_o));
  wl_link_props i_wl_link_props(.clk_i(clk_i), .arst_n_i(arst_n_i), .mrs_valid(link.mrs_valid),
    .mrs_sel(link.mrs_sel), .mrs_data(link.mrs_data), .term_ctl(link.term_ctl), .mem_clk(link.mem_clk),
    .strobe_oe(link.strobe_oe), .strobe_lvl(link.strobe_lvl), .dq_oe(link.dq_oe), .dq(link.dq));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // exp holds {pslverr, prdata}; read data is only compared on reads
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d, input logic [32:0] exp);
    int n;
    expq.push_back(exp);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) begin
      bad_count++;
      close_out();
    end else begin
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  // which 0 waits on leveling mode, 1 on termination control
  task automatic wait_on(input logic which, input logic v);
    int n;
    n = 0;
    while ((which ? link.term_ctl : lvl_mode_o) !== v && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if ((which ? link.term_ctl : lvl_mode_o) !== v) begin
      bad_count++;
      close_out();
    end
  endtask
  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      check("apb answer", {pslverr_o, pwrite_i ? e[31:0] : prdata_o}, e);
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    check("idle mode", 33'({lvl_mode_o, out_buf_off_o}), 33'h0);
    apb(1'b0, OFS_CTRL, 32'h0000_0000, 33'h0);
    apb(1'b0, OFS_STATUS, 32'h0000_0000, 33'h0);
    repeat (4) begin
      a = (xs() & 12'hFFC) | 12'h010;
      apb(1'b1, a, xs(), {1'b1, 32'h0000_0000});
      apb(1'b0, a, 32'h0000_0000, {1'b1, 32'h0000_0000});
    end
    apb(1'b0, OFS_DELAY, 32'h0000_0000, 33'h0);
    // full leveling pass with outputs on
    apb(1'b1, OFS_CTRL, 32'h0000_0001, 33'h0);
    wait_on(1'b0, 1'b1);
    @(posedge clk_i);
    check("entry term", 33'({strobe_term_on_o, dq_term_on_o, strobe_term_nom_o, out_buf_off_o, dyn_setting_o}),
      33'h40);
    check("settings", 33'({nom_setting_o, park_setting_o}), 33'h0);
    wait_on(1'b1, 1'b1);
    repeat (2) @(posedge clk_i);
    check("nominal", 33'({strobe_term_on_o, dq_term_on_o, strobe_term_nom_o}), 33'h5);
    // termination drops once both lanes locked; the last feedback is still on the lines
    wait_on(1'b1, 1'b0);
    check("locked fb", 33'({fb_o, link.dq}), 33'h3_FFFF);
    wait_on(1'b0, 1'b0);
    repeat (MODE_SET_CYC + 16) @(posedge clk_i);
    apb(1'b0, OFS_STATUS, 32'h0000_0000, 33'(3 << STAT_LOCK_LSB | 1 << STAT_DONE_BIT));
    apb(1'b0, OFS_DELAY, 32'h0000_0000, 33'({16'h0000, 8'(CK_HALF_DEF), 8'(CK_HALF_DEF)}));
    // pass with outputs off, cut short by a reset
    apb(1'b1, OFS_CTRL, 32'h0000_0003, 33'h0);
    apb(1'b0, OFS_CTRL, 32'h0000_0000, 33'h2);
    wait_on(1'b0, 1'b1);
    repeat (200) @(posedge clk_i);
    check("outputs off", {out_buf_off_o, link.dq_oe, link.dq}, {1'b1, 32'h0000_0000});
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("in reset", 33'({lvl_mode_o, out_buf_off_o, link.term_ctl, link.strobe_n}), 33'h3);
    arst_n_i <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0000_0000, 33'h0);
    repeat (2) @(posedge clk_i);
    check("queue empty", 33'(expq.size()), 33'h0);
    close_out();
  end
endmodule
